/* swt_params.svh */
`ifndef SWT_PARAMS_SVH
`define SWT_PARAMS_SVH

// clock rate and line timing (times in their own unit, counts derived)
`define SWT_CLK_MHZ 100
`define SWT_T_RST_US 480
`define SWT_T_PWAIT_US 30
`define SWT_T_PLOW_US 120
`define SWT_T_SLOT_US 30
`define SWT_T_CONV_MS 750
`define SWT_T_COPY_MS 10
`define SWT_T_LOAD_US 10
`define SWT_PWAIT_CYC (`SWT_T_PWAIT_US * `SWT_CLK_MHZ)
`define SWT_SLOT_CYC (`SWT_T_SLOT_US * `SWT_CLK_MHZ)
`define SWT_LOAD_CYC (`SWT_T_LOAD_US * `SWT_CLK_MHZ)

// identity and function command codes
`define SWT_CMD_SEARCH 8'hF0
`define SWT_CMD_READID 8'h33
`define SWT_CMD_MATCH 8'h55
`define SWT_CMD_SKIP 8'hCC
`define SWT_CMD_ALSRCH 8'hEC
`define SWT_CMD_CONV 8'h44
`define SWT_CMD_WRSP 8'h4E
`define SWT_CMD_RDSP 8'hBE
`define SWT_CMD_COPY 8'h48
`define SWT_CMD_RELOAD 8'hB8

// last bit index of each frame, one less than its length in bits
`define SWT_BYTE_LAST 3'h7
`define SWT_ID_LAST 7'h3F
`define SWT_SP_LAST 7'h47
`define SWT_WR_LAST 7'h17
`define SWT_SRCH_LAST 2'h2

// staging memory layout
`define SWT_SP_RSVD 8'hFF
`define SWT_CFG_RES_MASK 8'h60
`define SWT_CFG_FIXED 8'h1F
`define SWT_CFG_RES_LSB 5
`define SWT_CFG_RST 8'h7F
`define SWT_TH_RST 8'h00
`define SWT_TL_RST 8'h00
`define SWT_TEMP_RST 16'h0000
`define SWT_CRC_POLY 8'h8C
`define SWT_WR_TH 2'h0
`define SWT_WR_TL 2'h1

// identity code after reset; the value is arbitrary
`define SWT_ID_RST 64'h0000_0000_0000_0001

// register offsets
`define SWT_REG_ID_LO 8'h00
`define SWT_REG_ID_HI 8'h04
`define SWT_REG_SENSE 8'h08
`define SWT_REG_STATUS 8'h0C
`define SWT_REG_SP_LO 8'h10
`define SWT_REG_SP_HI 8'h14
`define SWT_REG_NV 8'h18
`define SWT_SENSE_ALARM 16
`define SWT_HSIZE_WORD 3'h2

`endif

/* swt_pkg.sv */
package swt_pkg;

	typedef enum logic [8:0]
	{
		ST_IDLE = 9'h001,
		ST_ROM_CMD = 9'h002,
		ST_ROM_TX = 9'h004,
		ST_MATCH = 9'h008,
		ST_SEARCH = 9'h010,
		ST_FN_CMD = 9'h020,
		ST_WR_SP = 9'h040,
		ST_RD_SP = 9'h080,
		ST_STATUS = 9'h100
	} swt_state_t;

	typedef enum logic [2:0]
	{
		BK_CONV = 3'h1,
		BK_COPY = 3'h2,
		BK_LOAD = 3'h4
	} swt_busy_t;

	typedef struct packed
	{
		logic valid;
		logic write;
		logic [7:0] addr;
	} swt_ahb_req_t;

	typedef struct packed
	{
		logic [7:0] cfg;
		logic [7:0] tl;
		logic [7:0] th;
	} swt_nvset_t;

endpackage

/* swt_crc8.sv */
`timescale 1ns/1ps
`include "swt_params.svh"

module swt_crc8 import swt_pkg::*;
(
	// staging bytes 0..7, byte 0 in the low bits
	input wire logic [63:0] data,
	// checksum
	output logic [7:0] crc
);
	logic fb;

	always_comb
	begin
		crc = 8'h00;
		fb = 1'b0;
		for (int i = 0; i < 64; i++)
		begin
			fb = crc[0] ^ data[i];
			crc = {1'b0, crc[7:1]} ^ (fb ? `SWT_CRC_POLY : 8'h00);
		end
	end

endmodule

/* swt_engine.sv */
`timescale 1ns/1ps
`include "swt_params.svh"

// Function
// - access runs reset, identity command, function command; otherwise silent.
// - after either search finishes, no function command until next reset.
// - five 8-bit identity commands act on the 64-bit identity first.
// - F0h joins the elimination search; master repeats until all found.
// - 33h sends the 64-bit identity; single slave only.
// - 55h compares 64 bits; mismatch idles until reset.
// - CCh selects without identity bits.
// - ECh searches only when the latest alarm flag is set.
// - 44h converts once, stores 2-byte temperature, returns idle.
// - 4Eh takes 3 bytes LSB first into bytes 2, 3, 4.
// - BEh sends bytes 0 through 8 LSB first, nine bytes.
// - a reset aborts a staging read and is handled normally.
// - 48h copies bytes 2, 3, 4 to nonvolatile storage.
// - B8h reloads bytes 2-4; read slots answer 0 busy, 1 done.
// - reload runs automatically at power-up.
// - reset low 480 us; presence after 15-60 us, for 60-240 us.
// - write slot sampled 15-60 us after the falling edge.
// - read 0 held low past 15 us, released before slot end.
module swt_engine import swt_pkg::*;
#(
	parameter int unsigned RST_CYC = `SWT_T_RST_US * `SWT_CLK_MHZ,
	parameter int unsigned PLOW_CYC = `SWT_T_PLOW_US * `SWT_CLK_MHZ,
	parameter int unsigned CONV_CYC = `SWT_T_CONV_MS * 1000 * `SWT_CLK_MHZ,
	parameter int unsigned COPY_CYC = `SWT_T_COPY_MS * 1000 * `SWT_CLK_MHZ
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// single-wire line, open drain
	input wire logic dq_in,
	output logic dq_out,
	output logic dq_oe_n
);
	localparam logic [15:0] RST_LAST = 16'(RST_CYC - 1);
	localparam logic [15:0] PWAIT = 16'(`SWT_PWAIT_CYC);
	localparam logic [15:0] PEND = 16'(`SWT_PWAIT_CYC + PLOW_CYC);
	localparam logic [15:0] SLOT = 16'(`SWT_SLOT_CYC);

	swt_ahb_req_t req_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic hresp_ff;
	logic dq_oe_n_ff;
	logic dq_out_ff;
	logic [63:0] id_ff;
	logic [15:0] sense_temp_ff;
	logic sense_alarm_ff;
	logic dq_q_ff;
	logic [15:0] lowcnt_ff;
	logic line_rst_ff;
	logic prs_act_ff;
	logic [15:0] prscnt_ff;
	logic slot_act_ff;
	logic [15:0] slotcnt_ff;
	logic slot_drv_ff;
	swt_state_t state_ff;
	logic [6:0] bitcnt_ff;
	logic [1:0] phase_ff;
	logic [7:0] rx_ff;
	logic busy_ff;
	swt_busy_t bkind_ff;
	logic [31:0] bcnt_ff;
	logic [15:0] temp_ff;
	logic alarm_ff;
	swt_nvset_t sp_ff;
	swt_nvset_t nv_ff;

	logic fall;
	logic rise;
	logic init_done;
	logic slot_done;
	logic rx_bit;
	logic [7:0] nxt_byte;
	logic tx_en;
	logic tx_bit;
	logic id_bit;
	logic [7:0] crc;
	logic [71:0] sp_vec;
	logic fn_byte;
	logic start_conv;
	logic start_copy;
	logic start_load;
	logic [31:0] btarget;
	logic nxt_oe_n;
	logic [31:0] nxt_hrdata;

	function automatic logic [31:0] conv_cycles(input logic [1:0] res);
		conv_cycles = CONV_CYC >> (2'h3 - res);
	endfunction

	function automatic logic is_id_cmd(input logic [7:0] b);
		is_id_cmd = (b == `SWT_CMD_SEARCH) || (b == `SWT_CMD_READID) ||
			(b == `SWT_CMD_MATCH) || (b == `SWT_CMD_SKIP) || (b == `SWT_CMD_ALSRCH);
	endfunction

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
	assign dq_oe_n = dq_oe_n_ff;
	assign dq_out = dq_out_ff;

	swt_crc8 u_crc
	(
		.data(sp_vec[63:0]),
		.crc(crc)
	);

	// staging image, byte 0 in the low bits; reserved bytes read all ones
	assign sp_vec = {crc, `SWT_SP_RSVD, `SWT_SP_RSVD, `SWT_SP_RSVD,
		sp_ff.cfg, sp_ff.tl, sp_ff.th, temp_ff};

	// ahb-lite slave: zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			req_ff <= '0;
			hrdata_ff <= 32'h0000_0000;
			hreadyout_ff <= 1'b1;
			hresp_ff <= 1'b0;
		end
		else
		begin
			req_ff.valid <= hsel && htrans[1] && hready && (hsize == `SWT_HSIZE_WORD);
			req_ff.write <= hwrite;
			req_ff.addr <= haddr[7:0];
			hrdata_ff <= nxt_hrdata;
		end
	end

	always_comb
	begin
		nxt_hrdata = hrdata_ff;
		if (hsel && htrans[1] && hready && !hwrite)
		begin
			case (haddr[7:0])
				`SWT_REG_ID_LO: nxt_hrdata = id_ff[31:0];
				`SWT_REG_ID_HI: nxt_hrdata = id_ff[63:32];
				`SWT_REG_SENSE: nxt_hrdata = {15'h0000, sense_alarm_ff, sense_temp_ff};
				`SWT_REG_STATUS: nxt_hrdata = {16'h0000, alarm_ff, bkind_ff, busy_ff, 2'h0, state_ff};
				`SWT_REG_SP_LO: nxt_hrdata = sp_vec[31:0];
				`SWT_REG_SP_HI: nxt_hrdata = {16'h0000, crc, sp_ff.cfg};
				`SWT_REG_NV: nxt_hrdata = {8'h00, nv_ff};
				default: nxt_hrdata = 32'h0000_0000;
			endcase
		end
	end

	// software-owned identity and sensor front-end values
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			id_ff <= `SWT_ID_RST;
			sense_temp_ff <= `SWT_TEMP_RST;
			sense_alarm_ff <= 1'b0;
		end
		else if (req_ff.valid && req_ff.write)
		begin
			case (req_ff.addr)
				`SWT_REG_ID_LO: id_ff[31:0] <= hwdata;
				`SWT_REG_ID_HI: id_ff[63:32] <= hwdata;
				`SWT_REG_SENSE:
				begin
					sense_temp_ff <= hwdata[15:0];
					sense_alarm_ff <= hwdata[`SWT_SENSE_ALARM];
				end
				default:
				begin
				end
			endcase
		end
	end

	// line edges; the pin is taken as synchronous
	assign fall = dq_q_ff && !dq_in;
	assign rise = !dq_q_ff && dq_in;
	assign init_done = rise && line_rst_ff;
	assign slot_done = slot_act_ff && (slotcnt_ff == SLOT);
	assign rx_bit = dq_in;

	// reset pulse detection
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dq_q_ff <= 1'b1;
			lowcnt_ff <= 16'h0000;
			line_rst_ff <= 1'b0;
		end
		else
		begin
			dq_q_ff <= dq_in;
			lowcnt_ff <= dq_in ? 16'h0000 : (lowcnt_ff == RST_LAST ? lowcnt_ff : lowcnt_ff + 16'h0001);
			if (!dq_in && lowcnt_ff == RST_LAST)
				line_rst_ff <= 1'b1;
			else if (rise)
				line_rst_ff <= 1'b0;
		end
	end

	// presence pulse after the reset pulse ends
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			prs_act_ff <= 1'b0;
			prscnt_ff <= 16'h0000;
		end
		else if (init_done)
		begin
			prs_act_ff <= 1'b1;
			prscnt_ff <= 16'h0000;
		end
		else if (prs_act_ff)
		begin
			prscnt_ff <= prscnt_ff + 16'h0001;
			if (prscnt_ff == PEND)
				prs_act_ff <= 1'b0;
		end
	end

	// bit slots: own presence pulses never open a slot; a reset pulse opens one like any other fall
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			slot_act_ff <= 1'b0;
			slotcnt_ff <= 16'h0000;
			slot_drv_ff <= 1'b0;
		end
		else if (fall && !prs_act_ff && !slot_act_ff)
		begin
			slot_act_ff <= 1'b1;
			slotcnt_ff <= 16'h0000;
			slot_drv_ff <= tx_en && !tx_bit;
		end
		else if (slot_act_ff)
		begin
			slotcnt_ff <= slotcnt_ff + 16'h0001;
			if (slot_done || init_done)
			begin
				slot_act_ff <= 1'b0;
				slot_drv_ff <= 1'b0;
			end
		end
	end

	// the pull-down is registered, so the line falls one cycle after the cause
	assign nxt_oe_n = !((prs_act_ff && prscnt_ff >= PWAIT && prscnt_ff < PEND) ||
		(slot_act_ff && slot_drv_ff));

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dq_oe_n_ff <= 1'b1;
			dq_out_ff <= 1'b0;
		end
		else
		begin
			dq_oe_n_ff <= nxt_oe_n;
			dq_out_ff <= 1'b0;
		end
	end

	// what the next read slot carries
	assign id_bit = id_ff[bitcnt_ff[5:0]];
	always_comb
	begin
		tx_en = 1'b0;
		tx_bit = 1'b1;
		case (state_ff)
			ST_ROM_TX:
			begin
				tx_en = 1'b1;
				tx_bit = id_bit;
			end
			ST_SEARCH:
			begin
				tx_en = (phase_ff != `SWT_SRCH_LAST);
				tx_bit = phase_ff[0] ? !id_bit : id_bit;
			end
			ST_RD_SP:
			begin
				tx_en = 1'b1;
				tx_bit = sp_vec[bitcnt_ff];
			end
			ST_STATUS:
			begin
				tx_en = 1'b1;
				tx_bit = !(busy_ff && bkind_ff == BK_LOAD);
			end
			default:
			begin
				tx_en = 1'b0;
				tx_bit = 1'b1;
			end
		endcase
	end

	assign nxt_byte = {rx_bit, rx_ff[7:1]};
	assign fn_byte = slot_done && state_ff == ST_FN_CMD && bitcnt_ff[2:0] == `SWT_BYTE_LAST;
	assign start_conv = fn_byte && nxt_byte == `SWT_CMD_CONV && !busy_ff;
	assign start_copy = fn_byte && nxt_byte == `SWT_CMD_COPY && !busy_ff;
	assign start_load = fn_byte && nxt_byte == `SWT_CMD_RELOAD && !busy_ff;

	// transaction sequencer
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= ST_IDLE;
			bitcnt_ff <= 7'h00;
			phase_ff <= 2'h0;
			rx_ff <= 8'h00;
		end
		else if (init_done)
		begin
			state_ff <= ST_ROM_CMD;
			bitcnt_ff <= 7'h00;
			phase_ff <= 2'h0;
		end
		else if (slot_done)
		begin
			rx_ff <= nxt_byte;
			bitcnt_ff <= bitcnt_ff + 7'h01;
			case (state_ff)
				ST_ROM_CMD:
				begin
					if (bitcnt_ff[2:0] == `SWT_BYTE_LAST)
					begin
						bitcnt_ff <= 7'h00;
						case (nxt_byte)
							`SWT_CMD_SEARCH: state_ff <= ST_SEARCH;
							`SWT_CMD_READID: state_ff <= ST_ROM_TX;
							`SWT_CMD_MATCH: state_ff <= ST_MATCH;
							`SWT_CMD_SKIP: state_ff <= ST_FN_CMD;
							`SWT_CMD_ALSRCH: state_ff <= alarm_ff ? ST_SEARCH : ST_IDLE;
							default: state_ff <= ST_IDLE;
						endcase
					end
				end
				ST_ROM_TX:
				begin
					if (bitcnt_ff == `SWT_ID_LAST)
					begin
						bitcnt_ff <= 7'h00;
						state_ff <= ST_FN_CMD;
					end
				end
				ST_MATCH:
				begin
					if (rx_bit != id_bit)
						state_ff <= ST_IDLE;
					else if (bitcnt_ff == `SWT_ID_LAST)
					begin
						bitcnt_ff <= 7'h00;
						state_ff <= ST_FN_CMD;
					end
				end
				ST_SEARCH:
				begin
					bitcnt_ff <= bitcnt_ff;
					phase_ff <= phase_ff + 2'h1;
					if (phase_ff == `SWT_SRCH_LAST)
					begin
						phase_ff <= 2'h0;
						bitcnt_ff <= bitcnt_ff + 7'h01;
						if (rx_bit != id_bit || bitcnt_ff == `SWT_ID_LAST)
							state_ff <= ST_IDLE;
					end
				end
				ST_FN_CMD:
				begin
					if (bitcnt_ff[2:0] == `SWT_BYTE_LAST)
					begin
						bitcnt_ff <= 7'h00;
						case (nxt_byte)
							`SWT_CMD_WRSP: state_ff <= ST_WR_SP;
							`SWT_CMD_RDSP: state_ff <= ST_RD_SP;
							`SWT_CMD_RELOAD: state_ff <= ST_STATUS;
							default: state_ff <= ST_IDLE;
						endcase
						if (is_id_cmd(nxt_byte))
							state_ff <= ST_IDLE;
					end
				end
				ST_WR_SP:
				begin
					if (bitcnt_ff == `SWT_WR_LAST)
						state_ff <= ST_IDLE;
				end
				ST_RD_SP:
				begin
					if (bitcnt_ff == `SWT_SP_LAST)
						state_ff <= ST_IDLE;
				end
				ST_STATUS:
				begin
					bitcnt_ff <= 7'h00;
				end
				default:
				begin
					bitcnt_ff <= 7'h00;
				end
			endcase
		end
	end

	// conversion, commit and reload timing; a reset pulse does not stop them
	assign btarget = (bkind_ff == BK_CONV) ? conv_cycles(sp_ff.cfg[`SWT_CFG_RES_LSB +: 2]) :
		(bkind_ff == BK_COPY) ? COPY_CYC : 32'(`SWT_LOAD_CYC);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			busy_ff <= 1'b1;
			bkind_ff <= BK_LOAD;
			bcnt_ff <= 32'h0000_0000;
		end
		else if (start_conv || start_copy || start_load)
		begin
			busy_ff <= 1'b1;
			bcnt_ff <= 32'h0000_0000;
			bkind_ff <= start_conv ? BK_CONV : (start_copy ? BK_COPY : BK_LOAD);
		end
		else if (busy_ff)
		begin
			bcnt_ff <= bcnt_ff + 32'h0000_0001;
			if (bcnt_ff >= btarget - 32'h0000_0001)
				busy_ff <= 1'b0;
		end
	end

	// staging bytes 0..4, nonvolatile copy and alarm flag
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			temp_ff <= `SWT_TEMP_RST;
			alarm_ff <= 1'b0;
			sp_ff <= {`SWT_CFG_RST, `SWT_TL_RST, `SWT_TH_RST};
			nv_ff <= {`SWT_CFG_RST, `SWT_TL_RST, `SWT_TH_RST};
		end
		else
		begin
			if (busy_ff && bcnt_ff >= btarget - 32'h0000_0001)
			begin
				case (bkind_ff)
					BK_CONV:
					begin
						temp_ff <= sense_temp_ff;
						alarm_ff <= sense_alarm_ff;
					end
					BK_COPY: nv_ff <= sp_ff;
					BK_LOAD: sp_ff <= nv_ff;
					default:
					begin
					end
				endcase
			end
			// each byte lands as soon as it is complete, so an early reset keeps earlier bytes
			if (slot_done && state_ff == ST_WR_SP && bitcnt_ff[2:0] == `SWT_BYTE_LAST)
			begin
				case (bitcnt_ff[4:3])
					`SWT_WR_TH: sp_ff.th <= nxt_byte;
					`SWT_WR_TL: sp_ff.tl <= nxt_byte;
					default: sp_ff.cfg <= (nxt_byte & `SWT_CFG_RES_MASK) | `SWT_CFG_FIXED;
				endcase
			end
		end
	end

endmodule

/* swt_dummy_end.sv */
`timescale 1ns/1ps

/* swt_engine_asserts.sv */
`timescale 1ns/1ps
module swt_engine_asserts import swt_pkg::*;
#(
	parameter int unsigned PLOW_CYC = 12000
)
(
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// line
	input wire logic dq_in,
	input wire logic dq_out,
	input wire logic dq_oe_n
);
	logic dq_prev_ff;
	logic [15:0] fcnt_ff;
	logic [15:0] hcnt_ff;
	logic [15:0] ocnt_ff;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// saturating counts: since the line fell, since it rose, and of our own pull
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dq_prev_ff <= 1'b1;
			fcnt_ff <= 16'hFFFF;
			hcnt_ff <= 16'hFFFF;
			ocnt_ff <= 16'h0000;
		end
		else
		begin
			dq_prev_ff <= dq_in;
			fcnt_ff <= (dq_prev_ff && !dq_in) ? 16'h0000 : fcnt_ff + 16'(fcnt_ff != 16'hFFFF);
			hcnt_ff <= (!dq_prev_ff && dq_in) ? 16'h0000 : hcnt_ff + 16'(hcnt_ff != 16'hFFFF);
			ocnt_ff <= dq_oe_n ? 16'h0000 : ocnt_ff + 16'(ocnt_ff != 16'hFFFF);
		end
	end
	sequence s_pull;
		$fell(dq_oe_n);
	endsequence
	// a pull either answers a read slot at once or is a presence 15..60 us after the rise
	property p_pull_cause;
		s_pull |-> fcnt_ff <= 16'h0003 || (hcnt_ff >= 16'h05DC && hcnt_ff <= 16'h1770);
	endproperty
	a_pull_cause: assert property (p_pull_cause)
		else $error("device pulled the line without a cause");
	// read pulls run about 30 us, so a shorter pull is a presence
	property p_pres_len;
		$rose(dq_oe_n) && ocnt_ff < 16'h0B54 |-> ocnt_ff >= PLOW_CYC - 2 && ocnt_ff <= PLOW_CYC + 2;
	endproperty
	a_pres_len: assert property (p_pres_len)
		else $error("presence length wrong");
	property p_read_hold;
		$rose(dq_oe_n) |-> ocnt_ff >= 16'h05DC;
	endproperty
	a_read_hold: assert property (p_read_hold)
		else $error("pull released before 15 us");
	property p_release;
		$past(!dq_oe_n) && !dq_oe_n |-> fcnt_ff < 16'h0C1C ||
			(hcnt_ff < fcnt_ff && hcnt_ff <= 16'h1770 + PLOW_CYC);
	endproperty
	a_release: assert property (p_release)
		else $error("pull outlasts the slot");
	property p_open_drain;
		dq_out == 1'b0;
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("line driven high");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay)
		else $error("error response");
	property p_ready;
		hreadyout == 1'b1;
	endproperty
	a_ready: assert property (p_ready)
		else $error("wait state inserted");
	property p_rd_hold;
		!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data changed without a read");
endmodule

bind swt_engine swt_engine_asserts #(.PLOW_CYC(PLOW_CYC)) swt_engine_asserts_inst (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

/* swt_line_master.sv */
`timescale 1ns/1ps
module swt_line_master import swt_pkg::*;
#(
	parameter int unsigned RST_LOW = 48100
)
(
	// clock
	input wire logic hclk,
	// line
	input wire logic dq,
	output logic low
);
	initial low = 1'b0;
	// one slot of 31 us; read-type slots are sampled at 10 us, inside the 15 us window
	task automatic slot(input logic b, output logic r);
		@(posedge hclk) low <= 1'b1;
		repeat (5) @(posedge hclk);
		low <= !b;
		repeat (1000) @(posedge hclk);
		r = dq;
		repeat (2100) @(posedge hclk);
		low <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask
	task automatic send(input logic [7:0] v);
		logic r;
		for (int i = 0; i < 8; i++) slot(v[i], r);
	endtask
	task automatic recv(input int nb, output logic [15:0] v);
		logic r;
		v = 16'h0000;
		for (int i = 0; i < nb; i++)
		begin
			slot(1'b1, r);
			v[i] = r;
		end
	endtask
	// the task waits 5000 cycles whether or not presence is seen, so the caller checks t0 and n
	task automatic line_reset(output int t0, output int n);
		@(posedge hclk) low <= 1'b1;
		repeat (RST_LOW) @(posedge hclk);
		low <= 1'b0;
		t0 = 0;
		n = 0;
		for (int i = 0; i < 5000; i++)
		begin
			@(posedge hclk);
			if (dq === 1'b0)
			begin
				if (n == 0) t0 = i;
				n++;
			end
		end
	endtask
	// strong pullup stands in as a quiet, released line
	task automatic hold_high(input int c);
		repeat (c) @(posedge hclk);
	endtask
endmodule

/* single_wire_sensor_cmd_engine_test.sv */
`timescale 1ns/1ps
module single_wire_sensor_cmd_engine_test import swt_pkg::*;
;
	typedef struct packed
	{
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
	} swt_row_t;
	localparam int unsigned PLOW = 1600;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dq_out, dq_oe_n, m_low, dq, r0, r1;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, sz;
	logic [15:0] bits;
	int fails, n_tests, cyc, t0, n;
	swt_row_t rows [11];
	assign dq = !(m_low || !dq_oe_n);
	swt_engine #(.RST_CYC(3200), .PLOW_CYC(PLOW), .CONV_CYC(800), .COPY_CYC(200)) swt_engine_inst
	(
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .dq_in(dq), .dq_out(dq_out), .dq_oe_n(dq_oe_n)
	);
	swt_line_master #(.RST_LOW(3300)) swt_line_master_inst (.hclk(hclk), .dq(dq), .low(m_low));
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	function automatic logic [7:0] crc8(input logic [63:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 64; i++) c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
		return c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= sz;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic pres();
		swt_line_master_inst.line_reset(t0, n);
		chk(32'(t0 >= 1500 && t0 <= 6000), 32'h1);
		chk(32'(n >= PLOW - 2 && n <= PLOW + 2), 32'h1);
	endtask
	task automatic end_sim();
		if (fails == 0 && n_tests > 0)
		begin
			$display("[ PASS ]");
		end
		else
		begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// the slots are fixed at 30 us, so the line tests alone need some 375k cycles
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 600000)
		begin
			fails++;
			end_sim();
		end
	end
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h0;
		sz = 3'h2;
		hwdata = 32'h0;
		fails = 0;
		n_tests = 0;
		cyc = 0;
		rows = '{'{1'b0, 8'h0C, 32'h0, 32'h4001}, '{1'b0, 8'h00, 32'h0, 32'h1},
			'{1'b0, 8'h04, 32'h0, 32'h0}, '{1'b0, 8'h18, 32'h0, 32'h007F0000},
			'{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b0, 8'h14, 32'h0, {16'h0, crc8(64'hFFFFFF7F00000000), 8'h7F}},
			'{1'b0, 8'h1C, 32'h0, 32'h0}, '{1'b1, 8'h08, 32'h00011234, 32'h0},
			'{1'b0, 8'h08, 32'h0, 32'h00011234}, '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0},
			'{1'b0, 8'h0C, 32'h0, 32'h4001}};
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, 8'h0C, 32'h0, rd);
		chk(rd, 32'h00004801);
		repeat (1100) @(posedge hclk);
		foreach (rows[i])
		begin
			ahb(rows[i].w, rows[i].a, rows[i].d, rd);
			if (!rows[i].w) chk(rd, rows[i].e);
		end
		// a byte-sized write must be ignored
		sz = 3'h0;
		ahb(1'b1, 8'h08, 32'h0, rd);
		sz = 3'h2;
		ahb(1'b0, 8'h08, 32'h0, rd);
		chk(rd, 32'h00011234);
		pres();
		swt_line_master_inst.send(8'hCC);
		swt_line_master_inst.send(8'h44);
		swt_line_master_inst.hold_high(1200);
		ahb(1'b0, 8'h0C, 32'h0, rd);
		chk(rd, 32'h00009001);
		ahb(1'b0, 8'h10, 32'h0, rd);
		chk(rd, 32'h00001234);
		ahb(1'b0, 8'h14, 32'h0, rd);
		chk(rd, {16'h0, crc8(64'hFFFFFF7F00001234), 8'h7F});
		pres();
		swt_line_master_inst.send(8'hCC);
		swt_line_master_inst.send(8'hBE);
		swt_line_master_inst.recv(16, bits);
		chk({16'h0, bits}, 32'h00001234);
		// reset in mid-read must still give a clean presence
		pres();
		ahb(1'b0, 8'h0C, 32'h0, rd);
		chk(rd, 32'h00009002);
		swt_line_master_inst.send(8'h00);
		swt_line_master_inst.slot(1'b1, r0);
		chk({31'h0, r0}, 32'h1);
		ahb(1'b0, 8'h0C, 32'h0, rd);
		chk(rd, 32'h00009001);
		pres();
		swt_line_master_inst.send(8'hEC);
		swt_line_master_inst.slot(1'b1, r0);
		swt_line_master_inst.slot(1'b1, r1);
		chk({30'h0, r0, r1}, 32'h2);
		pres();
		swt_line_master_inst.send(8'hCC);
		swt_line_master_inst.send(8'h4E);
		swt_line_master_inst.send(8'hA5);
		swt_line_master_inst.send(8'h5A);
		swt_line_master_inst.send(8'h00);
		ahb(1'b0, 8'h10, 32'h0, rd);
		chk(rd, 32'h5AA51234);
		ahb(1'b0, 8'h14, 32'h0, rd);
		chk(rd, {16'h0, crc8(64'hFFFFFF1F5AA51234), 8'h1F});
		end_sim();
	end
endmodule
